//--- rtl/stage_aux_command_io.sv
// Auxiliary command interpreter and isolated I/O for a one-axis stage controller.
// Assumes a classic Wishbone master on clk_i; pins arrive asynchronously; motion logic
// shares clk_i and reports homing completion and offset move completion as pulses.
`timescale 1ns/1ps
`default_nettype none

module stage_aux_command_io
	import stage_aux_pkg::*;
#(
	parameter logic [23:0] VERSION_CODE = 24'h000203,
	parameter logic [9:0] REVISION_CODE = 10'h02a
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] gp_input_lines_i,
	output logic [3:0] gp_output_lines_o,
	input wire logic first_limit_sensor_i,
	input wire logic second_limit_sensor_i,
	input wire logic jog_plus_input_i,
	input wire logic jog_minus_input_i,
	input wire logic emergency_halt_input_i,
	input wire logic emergency_enable_jumper_i,
	input wire logic homing_done_i,
	input wire logic offset_move_done_i,
	output logic offset_move_o,
	output logic [23:0] offset_pulses_o,
	output logic origin_set_o,
	output logic [14:0] jog_speed_o,
	output logic jog_plus_o,
	output logic jog_minus_o,
	output logic motion_stop_o,
	output logic start_inhibit_o,
	output logic windings_off_o
);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [14:0] trunc_step(input logic [14:0] v);
		logic [14:0] q;
		q = v / `JOG_STEP;
		return 15'(q * `JOG_STEP);
	endfunction

	// Pin synchronisers
	logic [9:0] sync1_q;
	logic [9:0] sync2_q;
	logic [3:0] gp_in;
	sensor_t sens;
	logic jumper;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= 10'h000;
			sync2_q <= 10'h000;
		end
		else
		begin
			sync1_q <= {emergency_enable_jumper_i, emergency_halt_input_i, jog_minus_input_i,
				jog_plus_input_i, second_limit_sensor_i, first_limit_sensor_i, gp_input_lines_i};
			sync2_q <= sync1_q;
		end
	end

	assign gp_in = sync2_q[3:0];
	assign sens = sync2_q[8:4];
	assign jumper = sync2_q[9];

	// Emergency state
	logic emergency_q;
	logic [1:0] config_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			emergency_q <= 1'b0;
			motion_stop_o <= 1'b0;
			start_inhibit_o <= 1'b0;
			windings_off_o <= 1'b0;
		end
		else
		begin
			emergency_q <= jumper && !sens.emergency;
			motion_stop_o <= emergency_q;
			start_inhibit_o <= emergency_q;
			windings_off_o <= emergency_q && config_q[`CFG_DEENERGISE_BIT];
		end
	end

	// Isolated jog inputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			jog_plus_o <= 1'b0;
			jog_minus_o <= 1'b0;
		end
		else
		begin
			// Both inputs on at once is ambiguous, so no jog
			jog_plus_o <= sens.jog_plus && !sens.jog_minus && !emergency_q;
			jog_minus_o <= sens.jog_minus && !sens.jog_plus && !emergency_q;
		end
	end

	// Wishbone slave
	logic ack_q;
	logic req;
	logic wr;
	logic [3:0] cmd_q;
	logic [31:0] param_q;
	logic exec_q;
	reply_t result_q;
	logic [23:0] offset_q;
	homing_state_t hm_q;
	logic [31:0] rd_d;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;

	always_comb
	begin
		rd_d = 32'h00000000;
		case (wb_adr_i)
			`OFS_CMD: rd_d = {28'h0000000, cmd_q};
			`OFS_PARAM: rd_d = param_q;
			`OFS_RESULT: rd_d = {6'h00, result_q};
			`OFS_CONFIG: rd_d = {30'h00000000, config_q};
			`OFS_STATUS:
			begin
				rd_d[`ST_BUSY_BIT] = exec_q;
				rd_d[`ST_EMERGENCY_BIT] = emergency_q;
				rd_d[`ST_JOG_PLUS_BIT] = jog_plus_o;
				rd_d[`ST_JOG_MINUS_BIT] = jog_minus_o;
				rd_d[`ST_OFS_MOVE_BIT] = offset_move_o;
				rd_d[`ST_SENSOR_LSB +: 5] = sens;
			end
			default: rd_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			ack_q <= req;
			wb_dat_o <= req ? rd_d : 32'h00000000;
		end
	end

	assign wb_ack_o = ack_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			param_q <= 32'h00000000;
			config_q <= `CFG_RESET;
		end
		else if (wr && wb_adr_i == `OFS_PARAM)
		begin
			param_q <= merge_bytes(param_q, wb_dat_i, wb_sel_i);
		end
		else if (wr && wb_adr_i == `OFS_CONFIG && wb_sel_i[0])
		begin
			config_q <= wb_dat_i[1:0];
		end
	end

	// Command launch: a write to CMD runs the command in the next cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_q <= 4'h0;
			exec_q <= 1'b0;
		end
		else if (wr && wb_adr_i == `OFS_CMD && wb_sel_i[0])
		begin
			cmd_q <= wb_dat_i[3:0];
			exec_q <= 1'b1;
		end
		else
		begin
			exec_q <= 1'b0;
		end
	end

	// Command execution
	reply_t res_d;
	logic out_we;
	logic ofs_we;
	logic jog_we;

	always_comb
	begin
		res_d = '{kind: `RES_NG, value: 24'h000000};
		out_we = 1'b0;
		ofs_we = 1'b0;
		jog_we = 1'b0;
		case (cmd_q)
			`OP_VERSION: res_d = '{kind: `RES_VALUE, value: VERSION_CODE};
			`OP_REVISION: res_d = '{kind: `RES_VALUE, value: {14'h0000, REVISION_CODE}};
			`OP_OUT_SET:
			begin
				if (param_q <= `OUT_MAX)
				begin
					out_we = 1'b1;
					res_d.kind = `RES_OK;
				end
			end
			`OP_IN_READ: res_d = '{kind: `RES_VALUE, value: {20'h00000, gp_in}};
			`OP_OFS_SET:
			begin
				if (param_q <= `OFS_MAX)
				begin
					ofs_we = 1'b1;
					res_d.kind = `RES_OK;
				end
			end
			`OP_OFS_READ: res_d = '{kind: `RES_VALUE, value: offset_q};
			`OP_JOG_SET:
			begin
				if (param_q >= `JOG_MIN && param_q <= `JOG_MAX)
				begin
					jog_we = 1'b1;
					res_d.kind = `RES_OK;
				end
			end
			`OP_JOG_READ: res_d = '{kind: `RES_VALUE, value: {9'h000, jog_speed_o}};
			`OP_SENSOR:
			begin
				if (param_q <= `SENSOR_MAX)
				begin
					res_d = '{kind: `RES_VALUE, value: {23'h000000, sens[param_q[2:0]]}};
				end
			end
			default: res_d = '{kind: `RES_NG, value: 24'h000000};
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			result_q <= '{kind: `RES_NONE, value: 24'h000000};
		end
		else if (exec_q)
		begin
			result_q <= res_d;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			gp_output_lines_o <= 4'h0;
		end
		else if (exec_q && out_we)
		begin
			gp_output_lines_o <= param_q[3:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			offset_q <= `OFS_RESET;
		end
		else if (exec_q && ofs_we)
		begin
			offset_q <= param_q[23:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			jog_speed_o <= `JOG_RESET;
		end
		else if (exec_q && jog_we)
		begin
			jog_speed_o <= trunc_step(param_q[14:0]);
		end
	end

	// Homing offset sequence
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hm_q <= HM_IDLE;
			offset_move_o <= 1'b0;
			offset_pulses_o <= 24'h000000;
			origin_set_o <= 1'b0;
		end
		else
		begin
			origin_set_o <= 1'b0;
			case (hm_q)
				HM_IDLE:
				begin
					if (homing_done_i)
					begin
						// Offset move only under near-limit homing and outside emergency
						if (config_q[`CFG_NEAR_LIMIT_BIT] && offset_q != 24'h000000 && !emergency_q)
						begin
							hm_q <= HM_OFFSET_MOVE;
							offset_move_o <= 1'b1;
							offset_pulses_o <= offset_q;
						end
						else if (!emergency_q)
						begin
							origin_set_o <= 1'b1;
						end
					end
				end
				HM_OFFSET_MOVE:
				begin
					if (emergency_q)
					begin
						hm_q <= HM_IDLE;
						offset_move_o <= 1'b0;
					end
					else if (offset_move_done_i)
					begin
						hm_q <= HM_IDLE;
						offset_move_o <= 1'b0;
						origin_set_o <= 1'b1;
					end
				end
				default:
				begin
					hm_q <= HM_IDLE;
					offset_move_o <= 1'b0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

//--- rtl/stage_aux_cfg.svh
// Constants for the auxiliary command and I/O block: offsets, fields, codes, limits.
// Assumes inclusion by bare name from the package and the bench.
`ifndef STAGE_AUX_CFG_SVH
`define STAGE_AUX_CFG_SVH

// Wishbone byte offsets
`define OFS_CMD 8'h00
`define OFS_PARAM 8'h04
`define OFS_RESULT 8'h08
`define OFS_CONFIG 8'h0c
`define OFS_STATUS 8'h10

// Command opcodes, written to CMD[3:0]
`define OP_VERSION 4'h1
`define OP_REVISION 4'h2
`define OP_OUT_SET 4'h3
`define OP_IN_READ 4'h4
`define OP_OFS_SET 4'h5
`define OP_OFS_READ 4'h6
`define OP_JOG_SET 4'h7
`define OP_JOG_READ 4'h8
`define OP_SENSOR 4'h9

// Result kinds, RESULT[25:24]
`define RES_NONE 2'h0
`define RES_OK 2'h1
`define RES_NG 2'h2
`define RES_VALUE 2'h3
`define RES_KIND_LSB 24

// CONFIG fields
`define CFG_NEAR_LIMIT_BIT 0
`define CFG_DEENERGISE_BIT 1
`define CFG_RESET 2'h1

// STATUS fields
`define ST_BUSY_BIT 0
`define ST_EMERGENCY_BIT 1
`define ST_JOG_PLUS_BIT 2
`define ST_JOG_MINUS_BIT 3
`define ST_OFS_MOVE_BIT 4
`define ST_SENSOR_LSB 8

// Ranges and reset values
`define OUT_MAX 32'h0000000f
`define OFS_MAX 32'h00ffffff
`define OFS_RESET 24'h000000
`define JOG_MIN 32'h00000064
`define JOG_MAX 32'h00004e20
`define JOG_STEP 15'h0064
`define JOG_RESET 15'h01f4
`define SENSOR_MAX 32'h00000004

`endif

//--- rtl/stage_aux_pkg.sv
// Types shared by the auxiliary command and I/O block.
// Assumes the constants header is on the include path.
package stage_aux_pkg;
	`include "stage_aux_cfg.svh"

	typedef struct packed {
		logic emergency;
		logic jog_minus;
		logic jog_plus;
		logic limit1;
		logic limit0;
	} sensor_t;

	typedef struct packed {
		logic [1:0] kind;
		logic [23:0] value;
	} reply_t;

	typedef enum logic [1:0] {
		HM_IDLE,
		HM_OFFSET_MOVE
	} homing_state_t;
endpackage

//--- sim/offset_motion_model.sv
// Motion logic stand-in: finishes an offset move after a fixed delay.
// Assumes the block's clock and reset.
`timescale 1ns/1ps
`default_nettype none
module offset_motion_model #(parameter int LAT = 6)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic move_i,
	output logic done_o
);
	int cnt_q;
	always_ff @(posedge clk_i)
	begin
		cnt_q <= (rst_i || !move_i || done_o) ? 0 : cnt_q + 1;
		done_o <= !rst_i && move_i && !done_o && cnt_q == LAT;
	end
endmodule
`default_nettype wire

//--- sim/stage_aux_command_io_asserts.sv
// Port checker for the auxiliary command and I/O block.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module stage_aux_command_io_asserts
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic homing_done_i,
	input wire logic offset_move_done_i,
	input wire logic offset_move_o,
	input wire logic [23:0] offset_pulses_o,
	input wire logic origin_set_o,
	input wire logic [14:0] jog_speed_o,
	input wire logic jog_plus_o,
	input wire logic jog_minus_o,
	input wire logic motion_stop_o,
	input wire logic start_inhibit_o,
	input wire logic windings_off_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack late");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
	a_reset_vals: assert property ($fell(rst_i) |-> jog_speed_o == 15'h01f4 && offset_pulses_o == 24'h0)
		else $error("reset value");
	a_jog_grid: assert property (jog_speed_o >= 100 && jog_speed_o <= 20000 && jog_speed_o % 100 == 0) else $error("jog speed");
	a_move_cause: assert property ($rose(offset_move_o) |-> $past(homing_done_i) && offset_pulses_o != 0)
		else $error("move start");
	a_move_end: assert property (offset_move_o && offset_move_done_i && !start_inhibit_o |=>
		!offset_move_o && (origin_set_o || start_inhibit_o)) else $error("move end");
	a_origin_pulse: assert property (origin_set_o |=> !origin_set_o) else $error("origin pulse");
	a_stop_pair: assert property (motion_stop_o == start_inhibit_o) else $error("stop pair");
	a_wind_emerg: assert property (windings_off_o |-> motion_stop_o) else $error("windings");
	a_jog_single: assert property (!(jog_plus_o && jog_minus_o)) else $error("both jogs");
endmodule
bind stage_aux_command_io stage_aux_command_io_asserts u_stage_aux_command_io_asserts (.*);
`default_nettype wire

//--- sim/tb_stage_aux_command_io.sv
// Bench for the auxiliary command and I/O block over Wishbone.
// Assumes the package and the constants header are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "stage_aux_cfg.svh"
module tb_stage_aux_command_io;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, wen = 0, hd = 0, emergency_enable_jumper = 0, mdone, omove, oset;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rdat, q;
	logic ack, jpo, jmo, stop, inh, wind;
	logic [3:0] gpi = 0, gpo;
	logic [4:0] s = 0;
	logic [23:0] opul;
	logic [14:0] jspd;
	int fails = 0, cmp_count = 0, org = 0;
	stage_aux_command_io #(.VERSION_CODE(24'h000305), .REVISION_CODE(10'h0e7))
		u_stage_aux_command_io (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.gp_input_lines_i(gpi), .gp_output_lines_o(gpo), .first_limit_sensor_i(s[0]), .second_limit_sensor_i(s[1]),
		.jog_plus_input_i(s[2]), .jog_minus_input_i(s[3]), .emergency_halt_input_i(s[4]),
		.emergency_enable_jumper_i(emergency_enable_jumper), .homing_done_i(hd), .offset_move_done_i(mdone), .offset_move_o(omove),
		.offset_pulses_o(opul), .origin_set_o(oset), .jog_speed_o(jspd), .jog_plus_o(jpo), .jog_minus_o(jmo),
		.motion_stop_o(stop), .start_inhibit_o(inh), .windings_off_o(wind));
	offset_motion_model u_offset_motion_model (.clk_i(clk_i), .rst_i(rst_i), .move_i(omove), .done_o(mdone));
	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic summarize();
		if (fails == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		wen <= we;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic cmd(input logic [3:0] op, input logic [31:0] p, input logic [1:0] k, input logic [23:0] v);
		wb(1, `OFS_PARAM, p);
		wb(1, `OFS_CMD, {28'h0, op});
		do wb(0, `OFS_STATUS, 0); while (q[0] !== 1'b0);
		wb(0, `OFS_RESULT, 0);
		chk(k == `RES_VALUE ? q : q & 32'h03000000, {6'h0, k, k == `RES_VALUE ? v : 24'h0});
	endtask
	task automatic home(input logic [31:0] cfg);
		wb(1, `OFS_CONFIG, cfg);
		org = 0;
		hd <= 1;
		@(posedge clk_i);
		hd <= 0;
		repeat (2)
		begin
			@(posedge clk_i);
			org += oset;
		end
	endtask
	task automatic pins(input logic [4:0] v, input logic j);
		s <= v;
		emergency_enable_jumper <= j;
		repeat (6) @(posedge clk_i);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_i);
		fails++;
		summarize();
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		wb(0, `OFS_CONFIG, 0);
		chk(q, {30'h0, `CFG_RESET});
		wb(0, 8'h40, 0);
		chk(q, 0);
		cmd(`OP_JOG_READ, 0, `RES_VALUE, 500);
		cmd(`OP_OFS_READ, 0, `RES_VALUE, 0);
		cmd(`OP_VERSION, 0, `RES_VALUE, 24'h000305);
		cmd(`OP_REVISION, 0, `RES_VALUE, 24'h0000e7);
		for (int i = 0; i < 16; i++)
		begin
			cmd(`OP_OUT_SET, i, `RES_OK, 0);
			chk(gpo, i);
			gpi <= 4'(15 - i);
			cmd(`OP_IN_READ, 0, `RES_VALUE, 15 - i);
		end
		cmd(`OP_OUT_SET, 16, `RES_NG, 0);
		chk(gpo, 15);
		cmd(`OP_OFS_SET, 32'h00ffffff, `RES_OK, 0);
		cmd(`OP_OFS_SET, 32'h01000000, `RES_NG, 0);
		cmd(`OP_OFS_READ, 0, `RES_VALUE, 24'hffffff);
		cmd(`OP_JOG_SET, 99, `RES_NG, 0);
		cmd(`OP_JOG_SET, 20001, `RES_NG, 0);
		cmd(`OP_JOG_SET, 1299, `RES_OK, 0);
		cmd(`OP_JOG_READ, 0, `RES_VALUE, 1200);
		chk(jspd, 1200);
		cmd(`OP_JOG_SET, 20000, `RES_OK, 0);
		chk(jspd, 20000);
		cmd(4'hf, 0, `RES_NG, 0);
		cmd(`OP_OFS_SET, 5, `RES_OK, 0);
		home(1);
		chk({omove, opul}, {1'b1, 24'h5});
		repeat (12)
		begin
			@(posedge clk_i);
			org += oset;
		end
		chk(omove, 0);
		chk(org, 1);
		home(0);
		chk(omove, 0);
		chk(org, 1);
		pins(5'b10110, 0);
		for (int i = 0; i < 5; i++)
			cmd(`OP_SENSOR, i, `RES_VALUE, s[i]);
		cmd(`OP_SENSOR, 5, `RES_NG, 0);
		pins(5'b00100, 0);
		chk({stop, jpo}, 2'b01);
		pins(5'b00100, 1);
		chk({stop, inh, jpo, wind}, 4'b1100);
		home(1);
		chk(omove, 0);
		chk(org, 0);
		wb(1, `OFS_CONFIG, 3);
		repeat (3) @(posedge clk_i);
		chk(wind, 1);
		pins(5'b11000, 1);
		chk({stop, inh, jpo, jmo, wind}, 5'b00010);
		rst_i <= 1;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		cmd(`OP_OFS_READ, 0, `RES_VALUE, 0);
		cmd(`OP_JOG_READ, 0, `RES_VALUE, 500);
		chk(jspd, 500);
		summarize();
	end
endmodule
`default_nettype wire
